// ---- shared/epio_pkg.sv ----
// Constants, register map and carrier types of the eight-pin I/O port.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz core clock.
package epio_pkg;

  localparam int unsigned EPIO_PINS = 8;
  localparam int unsigned EPIO_ADDR_W = 8;

  // Printed offsets are not multiples of four: they are indices, byte address = 4*index
  localparam logic [EPIO_ADDR_W-1:0] EPIO_IDX_OUT_LATCH = 8'h00;
  localparam logic [EPIO_ADDR_W-1:0] EPIO_IDX_PIN_LEVEL = 8'h01;
  localparam logic [EPIO_ADDR_W-1:0] EPIO_IDX_DIRECTION = 8'h02;
  localparam logic [EPIO_ADDR_W-1:0] EPIO_IDX_DRIVE_PULL = 8'h03;
  localparam logic [EPIO_ADDR_W-1:0] EPIO_IDX_IRQ_SPEED = 8'h04;
  localparam logic [EPIO_ADDR_W-1:0] EPIO_IDX_LAST = 8'h04;
  localparam int unsigned EPIO_IDX_LSB = 2;

  // Reset values
  localparam logic [7:0] EPIO_RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] EPIO_RST_DIRECTION = 8'h00;
  localparam logic [7:0] EPIO_RST_DRIVE_PULL = 8'h00;
  localparam logic [7:0] EPIO_RST_DRIVE_PULL_PORT_A = 8'h01;
  localparam logic [7:0] EPIO_RST_IRQ_SPEED = 8'h00;
  localparam logic [7:0] EPIO_ALL_ZERO = 8'h00;

  // Bus responses
  localparam logic [1:0] EPIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] EPIO_RESP_SLVERR = 2'h2;

  // Slope limits in MHz, informative only
  localparam int unsigned EPIO_SLOW_SLOPE_MHZ = 2;
  localparam int unsigned EPIO_FAST_SLOPE_MHZ = 10;

  // Per-pin pad controls, one bit per pin
  typedef struct packed {
    logic [7:0] outValue;
    logic [7:0] outEnable;
    logic [7:0] pushPull;
    logic [7:0] pullUpEnable;
    logic [7:0] fastSlope;
    logic [7:0] schmittEnable;
  } epio_pad_ctrl_s;

  // Alternate-function request from peripherals
  typedef struct packed {
    logic [7:0] active;
    logic [7:0] value;
  } epio_alt_out_s;

  // Converter controls reaching the pads
  typedef struct packed {
    logic [7:0] schmittDisable;
    logic [7:0] channelEnabled;
  } epio_adc_ctrl_s;

endpackage : epio_pkg

// ---- hdl/epio_sync2.sv ----
// Two-flop synchroniser for the asynchronous pin levels.
// Assumes only the second stage is read by downstream logic.
`timescale 1ns/1ps
`default_nettype none
module epio_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  // Both stages clear to zero in reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule // epio_sync2
`default_nettype wire

// ---- hdl/epio_port.sv ----
// Eight-pin general purpose I/O port with AXI4-Lite register access.
// Assumes pads outside resolve the pin from outValue/outEnable/pullUp;
// pin levels arrive from outside the clock domain;
// interrupt controller outside does edge selection and wake-up.
//
// Overview of operation
// - Reset leaves every pin input, driver off; port A pin 0 pulled up
// - Absent pins store writes but stay inert, level reads zero
// - Low power keeps port; enabled irqs wake
// - Input with enable bit raises pin request
// - Output direction suppresses pin interrupt request
// - Interrupts disabled at reset, enabled per pin
// - Converter disable bit turns off input buffer
// - Enabled converter channel disables Schmitt buffer
// - Alternate output overrides latch, forces output
// - Alternate output keeps drive and slope selections
// - Output latch at 0x00 reads latched value
// - Latch write in input mode stored only
// - Level register 0x01 reads sampled pin levels
// - Direction register 0x02: 1 output, reset 0
// - Control one: pull-up or push-pull selection
// - True open-drain pins ignore control one
// - Control one resets 0x00, port A 0x01
// - Control two enables irq where capable only
// - Control two picks fast slope where capable
// - Register bit n belongs to pin n
// - Direction 1, control 0/1 gives fast open-drain
`timescale 1ns/1ps
`default_nettype none
module epio_port
  import epio_pkg::*;
#(
  parameter bit IS_PORT_A = 1'b0,
  parameter logic [7:0] PIN_PRESENT = 8'hff,
  parameter logic [7:0] IRQ_CAPABLE = 8'hff,
  parameter logic [7:0] FAST_CAPABLE = 8'hff,
  parameter logic [7:0] TRUE_OPEN_DRAIN = 8'h00,
  parameter logic [7:0] ANALOG_CAPABLE = 8'hff
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [EPIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [EPIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and neighbours
  input wire logic [7:0] pinIn,
  input wire epio_pkg::epio_alt_out_s altOut,
  input wire epio_pkg::epio_adc_ctrl_s adcCtrl,
  output epio_pkg::epio_pad_ctrl_s padCtrl,
  output logic [7:0] pinIrqReq
);
  import epio_pkg::*;

  logic [7:0] outLatch_reg;
  logic [7:0] direction_reg;
  logic [7:0] drivePull_reg;
  logic [7:0] irqSpeed_reg;
  logic [7:0] pinSync;
  logic [7:0] pinLevel_reg;

  logic awHeld_reg;
  logic [EPIO_ADDR_W-1:0] awAddr_reg;
  logic wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;
  logic respStall;
  logic [EPIO_ADDR_W-1:0] wrIndex;
  logic [EPIO_ADDR_W-1:0] rdIndex;

  // Byte address to register index
  function automatic logic [EPIO_ADDR_W-1:0] toIndex(input logic [EPIO_ADDR_W-1:0] addr);
    toIndex = addr >> EPIO_IDX_LSB;
  endfunction

  // Index decode: only aligned words inside the map are mapped
  function automatic logic isMapped(input logic [EPIO_ADDR_W-1:0] addr);
    isMapped = (addr[EPIO_IDX_LSB-1:0] == '0) && (toIndex(addr) <= EPIO_IDX_LAST);
  endfunction

  // Pin inputs cross into the clock domain first
  epio_sync2 #(
    .WIDTH(EPIO_PINS)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  // Effective controls after alternate-function override
  logic [7:0] effDir;
  logic [7:0] effOut;
  logic [7:0] schmittOn;
  logic [7:0] usableLevel;
  assign effDir = (direction_reg | altOut.active) & PIN_PRESENT;
  assign effOut = (altOut.active & altOut.value) | (~altOut.active & outLatch_reg);
  assign schmittOn = ~(ANALOG_CAPABLE & (adcCtrl.schmittDisable | adcCtrl.channelEnabled));
  // One gated level feeds both the level register and the requests
  assign usableLevel = pinSync & schmittOn & PIN_PRESENT;

  // Write channel capture; address and data accepted in either order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
    else if (doWrite)
    begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end
    else if (doWrite)
    begin
      wHeld_reg <= 1'b0;
    end
  end

  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign respStall = s_axi_bvalid && !s_axi_bready;
  assign wrIndex = toIndex(awAddr_reg);

  // Address ready while the slot is free and no response waits; keeping
  // it low under an unanswered response keeps one write in flight
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !respStall;
    end
  end

  // Data ready follows the same rule as the address side
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !respStall;
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Response code fixed when the write is performed
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bresp <= EPIO_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bresp <= isMapped(awAddr_reg) ? EPIO_RESP_OKAY : EPIO_RESP_SLVERR;
    end
  end

  // Register file; absent pins accept writes but the bits stay inert
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      outLatch_reg <= EPIO_RST_OUT_LATCH;
      direction_reg <= EPIO_RST_DIRECTION;
      drivePull_reg <= IS_PORT_A ? EPIO_RST_DRIVE_PULL_PORT_A : EPIO_RST_DRIVE_PULL;
      irqSpeed_reg <= EPIO_RST_IRQ_SPEED;
    end
    else if (doWrite && wStrb_reg[0] && isMapped(awAddr_reg))
    begin
      // Only the low byte lane holds data; bit n is pin n
      case (wrIndex)
        EPIO_IDX_OUT_LATCH: outLatch_reg <= wData_reg[7:0];
        EPIO_IDX_DIRECTION: direction_reg <= wData_reg[7:0];
        EPIO_IDX_DRIVE_PULL: drivePull_reg <= wData_reg[7:0];
        EPIO_IDX_IRQ_SPEED: irqSpeed_reg <= wData_reg[7:0];
        default: ;
      endcase
    end
  end

  // Level register: buffer off or absent pin reads low
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pinLevel_reg <= EPIO_ALL_ZERO;
    end
    else
    begin
      pinLevel_reg <= usableLevel;
    end
  end

  // Read channel, answer one cycle after address
  assign rdIndex = toIndex(s_axi_araddr);
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= EPIO_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(s_axi_araddr) ? EPIO_RESP_OKAY : EPIO_RESP_SLVERR;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid || s_axi_rready;
    end
  end

  // Read data captured with the address; upper lanes always read zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rdata <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rdata <= '0;
      if (isMapped(s_axi_araddr))
      begin
        case (rdIndex)
          EPIO_IDX_OUT_LATCH: s_axi_rdata[7:0] <= outLatch_reg;
          EPIO_IDX_PIN_LEVEL: s_axi_rdata[7:0] <= pinLevel_reg;
          EPIO_IDX_DIRECTION: s_axi_rdata[7:0] <= direction_reg;
          EPIO_IDX_DRIVE_PULL: s_axi_rdata[7:0] <= drivePull_reg;
          EPIO_IDX_IRQ_SPEED: s_axi_rdata[7:0] <= irqSpeed_reg;
          default: s_axi_rdata[7:0] <= EPIO_ALL_ZERO;
        endcase
      end
    end
  end

  // Pad controls; nothing here depends on low-power state, so wait and
  // halt leave the pads exactly as programmed
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      padCtrl.outValue <= EPIO_ALL_ZERO;
      padCtrl.outEnable <= EPIO_ALL_ZERO;
      padCtrl.pushPull <= EPIO_ALL_ZERO;
      padCtrl.pullUpEnable <= EPIO_ALL_ZERO;
      padCtrl.fastSlope <= EPIO_ALL_ZERO;
      padCtrl.schmittEnable <= EPIO_ALL_ZERO;
    end
    else
    begin
      // Pseudo-open-drain drives only the low level
      padCtrl.outValue <= effOut & effDir;
      padCtrl.outEnable <= effDir & (drivePull_reg & ~TRUE_OPEN_DRAIN | ~effOut);
      padCtrl.pushPull <= effDir & drivePull_reg & ~TRUE_OPEN_DRAIN;
      padCtrl.pullUpEnable <= ~effDir & drivePull_reg & ~TRUE_OPEN_DRAIN & PIN_PRESENT;
      padCtrl.fastSlope <= effDir & irqSpeed_reg & FAST_CAPABLE;
      padCtrl.schmittEnable <= schmittOn & PIN_PRESENT;
    end
  end

  // Interrupt requests, also the wake source in wait and halt
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pinIrqReq <= EPIO_ALL_ZERO;
    end
    else
    begin
      pinIrqReq <= usableLevel & ~effDir & irqSpeed_reg & IRQ_CAPABLE;
    end
  end

endmodule // epio_port
`default_nettype wire

// ---- tb/epio_pins_model.sv ----
// Board model: resolves each pin from pad controls and outside drivers.
// Assumes the port's pad outputs; pins nobody drives show a toggling level.
`timescale 1ns/1ps
`default_nettype none
module epio_pins_model (
  input wire logic core_clk,
  input wire epio_pkg::epio_pad_ctrl_s padCtrl,
  input wire logic [7:0] extDrive,
  input wire logic [7:0] extLevel,
  output logic [7:0] pinIn
);
  import epio_pkg::*;
  logic [7:0] floatPat_reg = 8'h5a;
  // Floating pins flip each cycle so no stale value is trusted
  always_ff @(posedge core_clk)
    floatPat_reg <= ~floatPat_reg;
  // Port driver wins, then outside driver, then weak pull-up
  always_comb
    pinIn = (padCtrl.outEnable & padCtrl.outValue)
      | (~padCtrl.outEnable & extDrive & extLevel)
      | (~padCtrl.outEnable & ~extDrive & (padCtrl.pullUpEnable | floatPat_reg));
endmodule // epio_pins_model
`default_nettype wire

// ---- tb/epio_port_sva.sv ----
// Checker for the I/O port, bound to the port's top-level pins.
// Assumes padCtrl and pinIrqReq are registered one edge after their cause.
`timescale 1ns/1ps
`default_nettype none
module epio_port_sva #(
  parameter logic [7:0] PIN_PRESENT = 8'hff,
  parameter logic [7:0] ANALOG_CAPABLE = 8'hff
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire epio_pkg::epio_alt_out_s altOut,
  input wire epio_pkg::epio_adc_ctrl_s adcCtrl,
  input wire epio_pkg::epio_pad_ctrl_s padCtrl,
  input wire logic [7:0] pinIrqReq
);
  import epio_pkg::*;
  logic [7:0] altAct_reg;
  logic [7:0] altVal_reg;
  logic [7:0] anaOff_reg;
  // Inputs one edge back, to line up with the registered pad controls
  always_ff @(posedge core_clk)
  begin
    altAct_reg <= altOut.active;
    altVal_reg <= altOut.value;
    anaOff_reg <= (adcCtrl.schmittDisable | adcCtrl.channelEnabled) & ANALOG_CAPABLE;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_RESP: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (rdTaken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_ALT_DRIVE: assert property (
    ((padCtrl.outValue ^ altVal_reg) & altAct_reg & padCtrl.outEnable) == 8'h0)
    else $error("alternate value not on pin");
  AST_IRQ_OUT: assert property ((pinIrqReq & padCtrl.outEnable) == 8'h0)
    else $error("request from driven pin");
  AST_ABSENT: assert property (
    ((pinIrqReq | padCtrl.outEnable) & ~PIN_PRESENT) == 8'h0)
    else $error("absent pin active");
  AST_SCHMITT: assert property ((padCtrl.schmittEnable & anaOff_reg) == 8'h0)
    else $error("input buffer left on");
  AST_PULL_OUT: assert property ((padCtrl.pullUpEnable & padCtrl.outEnable) == 8'h0)
    else $error("pull-up on driven pin");
  AST_RESET_OFF: assert property ($rose(rst_n) |-> padCtrl.outEnable == 8'h0
    && pinIrqReq == 8'h0)
    else $error("pin active after reset");
endmodule // epio_port_sva
bind epio_port epio_port_sva #(.PIN_PRESENT(PIN_PRESENT), .ANALOG_CAPABLE(ANALOG_CAPABLE)) u_sva (
  .core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .altOut, .adcCtrl, .padCtrl, .pinIrqReq);
`default_nettype wire

// ---- tb/epio_port_test.sv ----
// Self-checking bench for the I/O port through AXI4-Lite calls.
// Assumes the pins model as board; pin 7 absent, pin 4 without interrupt.
`timescale 1ns/1ps
`default_nettype none
module epio_port_test;
  import epio_pkg::*;
  localparam logic [7:0] ADDR_LAT = EPIO_IDX_OUT_LATCH << EPIO_IDX_LSB;
  localparam logic [7:0] ADDR_LVL = EPIO_IDX_PIN_LEVEL << EPIO_IDX_LSB;
  localparam logic [7:0] ADDR_DIR = EPIO_IDX_DIRECTION << EPIO_IDX_LSB;
  localparam logic [7:0] ADDR_DP = EPIO_IDX_DRIVE_PULL << EPIO_IDX_LSB;
  localparam logic [7:0] ADDR_IS = EPIO_IDX_IRQ_SPEED << EPIO_IDX_LSB;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] extLevel = 8'hff;
  epio_alt_out_s altOut = '0;
  epio_adc_ctrl_s adcCtrl = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pinIn, pinIrqReq;
  epio_pad_ctrl_s padCtrl;
  int nErrors = 0;
  int nChecks = 0;
  epio_port #(.IS_PORT_A(1'b1), .PIN_PRESENT(8'h7f), .IRQ_CAPABLE(8'hef),
    .FAST_CAPABLE(8'hfd)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pinIn(pinIn), .altOut(altOut), .adcCtrl(adcCtrl), .padCtrl(padCtrl),
    .pinIrqReq(pinIrqReq));
  epio_pins_model board_u (.core_clk(core_clk), .padCtrl(padCtrl), .extDrive(8'hff),
    .extLevel(extLevel), .pinIn(pinIn));
  // Free-running 100 MHz clock
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    chk8({6'h0, bresp}, {6'h0, er});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    if (er === EPIO_RESP_OKAY) chk(rdata, ed);
    chk8({6'h0, rresp}, {6'h0, er});
    rready <= 1'b0;
  endtask
  // Pad register, two sync stages, then the output register
  task automatic settle;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic giveVerdict;
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    chk8(padCtrl.outEnable, 8'h00);
    chk8(padCtrl.pullUpEnable, 8'h01);
    rd(ADDR_LAT, 32'h0, EPIO_RESP_OKAY);
    rd(ADDR_DIR, 32'h0, EPIO_RESP_OKAY);
    rd(ADDR_DP, {24'h0, EPIO_RST_DRIVE_PULL_PORT_A}, EPIO_RESP_OKAY);
    rd(ADDR_IS, 32'h0, EPIO_RESP_OKAY);
    rd(ADDR_LVL, 32'h7f, EPIO_RESP_OKAY);
    wr(ADDR_LAT, 32'ha5, EPIO_RESP_OKAY);
    settle();
    chk8(padCtrl.outEnable, 8'h00);
    rd(ADDR_LAT, 32'ha5, EPIO_RESP_OKAY);
    // Low byte lane disabled: write answered but the latch keeps its value
    wstrb <= 4'he;
    wr(ADDR_LAT, 32'h00, EPIO_RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_LAT, 32'ha5, EPIO_RESP_OKAY);
    wr(ADDR_DP, 32'hff, EPIO_RESP_OKAY);
    wr(ADDR_DIR, 32'hff, EPIO_RESP_OKAY);
    settle();
    chk8(padCtrl.outEnable, 8'h7f);
    chk8(padCtrl.outValue & 8'h7f, 8'h25);
    rd(ADDR_LVL, 32'h25, EPIO_RESP_OKAY);
    wr(ADDR_DP, 32'h00, EPIO_RESP_OKAY);
    wr(ADDR_IS, 32'hff, EPIO_RESP_OKAY);
    settle();
    chk8(padCtrl.outEnable, 8'h5a);
    chk8(padCtrl.fastSlope, 8'h7d);
    chk8(pinIrqReq, 8'h00);
    extLevel <= 8'hf0;
    wr(ADDR_DIR, 32'h00, EPIO_RESP_OKAY);
    settle();
    rd(ADDR_LVL, 32'h70, EPIO_RESP_OKAY);
    chk8(pinIrqReq, 8'h60);
    wr(ADDR_IS, 32'h20, EPIO_RESP_OKAY);
    settle();
    chk8(pinIrqReq, 8'h20);
    adcCtrl <= '{schmittDisable: 8'h10, channelEnabled: 8'h20};
    settle();
    rd(ADDR_LVL, 32'h40, EPIO_RESP_OKAY);
    chk8(padCtrl.schmittEnable, 8'h4f);
    chk8(pinIrqReq, 8'h00);
    adcCtrl <= '0;
    wr(ADDR_IS, 32'h00, EPIO_RESP_OKAY);
    wr(ADDR_DP, 32'h08, EPIO_RESP_OKAY);
    altOut <= '{active: 8'h08, value: 8'h08};
    settle();
    chk8(padCtrl.outEnable & 8'h08, 8'h08);
    chk8(padCtrl.outValue & 8'h08, 8'h08);
    chk8(padCtrl.pushPull & 8'h08, 8'h08);
    // Second reset with alternate drive withdrawn: programmed state must clear
    rst_n <= 1'b0;
    altOut <= '0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    chk8(padCtrl.outEnable, 8'h00);
    chk8(padCtrl.pullUpEnable, 8'h01);
    rd(ADDR_LAT, 32'h0, EPIO_RESP_OKAY);
    rd(ADDR_DP, {24'h0, EPIO_RST_DRIVE_PULL_PORT_A}, EPIO_RESP_OKAY);
    wr(8'h14, 32'hff, EPIO_RESP_SLVERR);
    rd(8'h14, 32'h0, EPIO_RESP_SLVERR);
    giveVerdict();
  end
  // Watchdog far beyond the expected run length
  initial
  begin
    #200us;
    nErrors++;
    giveVerdict();
  end
endmodule // epio_port_test
`default_nettype wire
